// ==== tick_timer_pkg.sv ====
// package: register map, field layout and constants of the tick timer
package tick_timer_pkg;
    localparam int unsigned   ADDR_W          = 8;
    localparam int unsigned   DATA_W          = 32;
    localparam int unsigned   CNT_W_DEF       = 24;
    // register byte offsets
    localparam logic [7:0]    OFF_CTRL_STATUS = 8'h10;
    localparam logic [7:0]    OFF_RELOAD      = 8'h14;
    localparam logic [7:0]    OFF_CURRENT     = 8'h18;
    localparam logic [7:0]    OFF_CALIB       = 8'h1C;
    localparam logic [7:0]    OFF_IRQ_STATUS  = 8'h20;
    localparam logic [7:0]    OFF_IRQ_MASK    = 8'h24;
    // tick_control_status fields
    localparam int unsigned   CSR_ENABLE_BIT  = 0;
    localparam int unsigned   CSR_IRQEN_BIT   = 1;
    localparam int unsigned   CSR_CLKSEL_BIT  = 2;
    localparam int unsigned   CSR_WRAP_BIT    = 16;
    // tick_calibration_properties fields
    localparam int unsigned   CAL_NO_REF_CLOCK_FLAG_BIT   = 31;
    localparam int unsigned   CAL_INEXACT_BIT = 30;
    localparam logic [23:0]   CAL_TEN_MS      = 24'h000000;
    localparam logic [31:0]   CAL_VALUE       = {1'b1, 1'b1, 6'h00, CAL_TEN_MS};
    // interrupt status / mask layout
    localparam int unsigned   IRQ_W           = 1;
    localparam int unsigned   IRQ_ZERO_BIT    = 0;
    // reset values
    localparam logic [31:0]   RST_WORD        = 32'h00000000;
endpackage : tick_timer_pkg

// ==== tick_source_sel.sv ====
// module: timer clock source selection, gated by the interrupt controller clock
`timescale 1ns/1ps
`default_nettype none
module tick_source_sel
    import tick_timer_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic ctl_clk_run_i,
    input  wire logic ref_tick_i,
    input  wire logic clk_select_i,
    output logic      count_en_o
);
    typedef struct packed {
        logic ref_prev;
    } src_st_t;

    src_st_t st_ff;
    src_st_t nxt_st;

    // remember the reference level to find its rising edge
    always_comb
    begin
        nxt_st          = st_ff;
        nxt_st.ref_prev = ref_tick_i;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    // nothing counts while the interrupt controller clock is stopped
    assign count_en_o = ctl_clk_run_i &&
                        (clk_select_i || (ref_tick_i && !st_ff.ref_prev));
endmodule : tick_source_sel
`default_nettype wire

// ==== tick_timer.sv ====
// module: 24-bit down-counting tick timer with calibration register and interrupt
//
// Function
// - calibration bit 31 reads one: no separate reference clock.
// - calibration bit 30 reads one: ten millisecond value inexact.
// - calibration bits 23:0 read zero: no calibration count.
// - counter advances only while the interrupt controller clock runs.
// - enabled counter decrements, reloads from zero next tick, continues.
// - wrap flag set on reaching zero, cleared by control register read.
// - current write clears value and wrap flag, reloads next tick, no request.
// - reaching zero raises a request only with interrupt enable bit set.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tick_timer
    import tick_timer_pkg::*;
#(
    parameter int unsigned CNT_W = CNT_W_DEF
)(
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              ctl_clk_run_i,
    input  wire logic              ref_tick_i,
    output logic                   irq_o
);
    typedef struct packed {
        logic              enable;
        logic              irq_en;
        logic              clk_sel;
        logic              wrap;
        logic [CNT_W-1:0]  reload;
        logic [CNT_W-1:0]  current;
        logic [IRQ_W-1:0]  irq_status;
        logic [IRQ_W-1:0]  irq_mask;
        logic [DATA_W-1:0] rdata;
    } tmr_st_t;

    tmr_st_t          st_ff;
    tmr_st_t          nxt_st;
    logic             count_en;
    logic             cur_wr;
    logic             csr_rd;
    logic             step;
    logic             hit;
    logic [DATA_W-1:0] rd_word;

    tick_source_sel u_src (
        .mclk_i        (mclk_i),
        .rst_n_i       (rst_n_i),
        .ctl_clk_run_i (ctl_clk_run_i),
        .ref_tick_i    (ref_tick_i),
        .clk_select_i  (st_ff.clk_sel),
        .count_en_o    (count_en)
    );

    // decode; the port carries whole words only, so no lane handling
    assign cur_wr = wr_i && (addr_i == OFF_CURRENT);
    assign csr_rd = rd_i && (addr_i == OFF_CTRL_STATUS);
    assign step   = st_ff.enable && count_en && !cur_wr;
    assign hit    = step && (st_ff.current == CNT_W'(1));         // one to zero

    // read mux; calibration word is a constant, independent of any write
    always_comb
    begin
        rd_word = '0;
        case (addr_i)
            OFF_CTRL_STATUS:
            begin
                rd_word[CSR_ENABLE_BIT] = st_ff.enable;
                rd_word[CSR_IRQEN_BIT]  = st_ff.irq_en;
                rd_word[CSR_CLKSEL_BIT] = st_ff.clk_sel;
                rd_word[CSR_WRAP_BIT]   = st_ff.wrap;
            end
            OFF_RELOAD:     rd_word[CNT_W-1:0] = st_ff.reload;
            OFF_CURRENT:    rd_word[CNT_W-1:0] = st_ff.current;
            OFF_CALIB:      rd_word = CAL_VALUE;
            OFF_IRQ_STATUS: rd_word[IRQ_W-1:0] = st_ff.irq_status;
            OFF_IRQ_MASK:   rd_word[IRQ_W-1:0] = st_ff.irq_mask;
            default:        rd_word = '0;                         // unmapped reads zero
        endcase
    end

    // next state: register writes, counting, flags
    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.rdata = rd_i ? rd_word : '0;
        if (wr_i)
        begin
            case (addr_i)
                OFF_CTRL_STATUS:
                begin
                    nxt_st.enable  = wdata_i[CSR_ENABLE_BIT];
                    nxt_st.irq_en  = wdata_i[CSR_IRQEN_BIT];
                    nxt_st.clk_sel = wdata_i[CSR_CLKSEL_BIT];
                end
                OFF_RELOAD:   nxt_st.reload   = wdata_i[CNT_W-1:0];
                OFF_IRQ_MASK: nxt_st.irq_mask = wdata_i[IRQ_W-1:0];
                OFF_IRQ_STATUS:
                    nxt_st.irq_status = st_ff.irq_status & ~wdata_i[IRQ_W-1:0];
                default: ;                                        // calibration ignores writes
            endcase
        end
        // a zero current value makes the next tick load the reload value
        if (cur_wr)
        begin
            nxt_st.current = '0;
            nxt_st.wrap    = 1'b0;
        end
        else if (step)
        begin
            if (st_ff.current == '0)
                nxt_st.current = st_ff.reload;
            else
                nxt_st.current = st_ff.current - 1'b1;
        end
        // set wins over the read clear so a wrap is never lost
        if (hit)
            nxt_st.wrap = 1'b1;
        else if (csr_rd)
            nxt_st.wrap = 1'b0;
        // request only with interrupt enable; a current write never gets here
        if (hit && st_ff.irq_en)
            nxt_st.irq_status[IRQ_ZERO_BIT] = 1'b1;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign rdata_o = st_ff.rdata;
    assign irq_o   = |(st_ff.irq_status & st_ff.irq_mask);

    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_no_ref_clock_flag;
        rd_i && (addr_i == OFF_CALIB) |=> rdata_o[CAL_NO_REF_CLOCK_FLAG_BIT];
    endproperty
    a_no_ref_clock_flag: assert property (p_no_ref_clock_flag) else $error("calibration no-ref bit not one");

    property p_inexact;
        rd_i && (addr_i == OFF_CALIB) |=> rdata_o[CAL_INEXACT_BIT];
    endproperty
    a_inexact: assert property (p_inexact) else $error("calibration inexact bit not one");

    property p_ten_ms_calib_count;
        rd_i && (addr_i == OFF_CALIB) |=> (rdata_o[CNT_W_DEF-1:0] == CAL_TEN_MS);
    endproperty
    a_ten_ms_calib_count: assert property (p_ten_ms_calib_count) else $error("calibration count not zero");

    property p_calib_fixed;
        wr_i && (addr_i == OFF_CALIB) ##1 rd_i && (addr_i == OFF_CALIB)
            |=> (rdata_o == CAL_VALUE);
    endproperty
    a_calib_fixed: assert property (p_calib_fixed) else $error("calibration changed by write");

    property p_halt;
        !ctl_clk_run_i && !cur_wr |=> (st_ff.current == $past(st_ff.current));
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved with clock stopped");

    property p_dec;
        step && (st_ff.current != '0) |=> (st_ff.current == $past(st_ff.current) - 1'b1);
    endproperty
    a_dec: assert property (p_dec) else $error("counter did not decrement");

    property p_reload;
        step && (st_ff.current == '0) |=> (st_ff.current == $past(st_ff.reload));
    endproperty
    a_reload: assert property (p_reload) else $error("counter did not reload at zero");

    property p_wrap_set;
        hit |=> st_ff.wrap ##1 (csr_rd || !$past(csr_rd) || !st_ff.wrap);
    endproperty
    a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set at zero");

    property p_wrap_clr;
        csr_rd && !hit |=> !st_ff.wrap;
    endproperty
    a_wrap_clr: assert property (p_wrap_clr) else $error("wrap flag not cleared by read");

    property p_cur_wr;
        cur_wr |=> (st_ff.current == '0) && !st_ff.wrap && ($stable(st_ff.irq_status) || !$past(wr_i));
    endproperty
    a_cur_wr: assert property (p_cur_wr) else $error("current write did not clear");

    property p_req;
        $rose(st_ff.irq_status[IRQ_ZERO_BIT]) |-> $past(hit) && $past(st_ff.irq_en);
    endproperty
    a_req: assert property (p_req) else $error("request without enable at zero");

    property p_req_set;
        hit && st_ff.irq_en |=> st_ff.irq_status[IRQ_ZERO_BIT] ##1 (irq_o || !st_ff.irq_mask[IRQ_ZERO_BIT] || !st_ff.irq_status[IRQ_ZERO_BIT]);
    endproperty
    a_req_set: assert property (p_req_set) else $error("zero event lost");

    c_wrap:   cover property (hit ##1 csr_rd);
    c_reload: cover property (step && (st_ff.current == '0) && (st_ff.reload != '0));
    c_irq:    cover property ($rose(irq_o));
    c_halt:   cover property (st_ff.enable && !ctl_clk_run_i ##1 ctl_clk_run_i);
endmodule : tick_timer
`default_nettype wire

// ==== tick_timer_tb.sv ====
// testbench: registers, calibration, counting and interrupt of the tick timer
`timescale 1ns/1ps
`default_nettype none
module tick_timer_tb
    import tick_timer_pkg::*;
;
    logic              mclk_i;
    logic              rst_n_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic              wr_i;
    logic              rd_i;
    logic [DATA_W-1:0] rdata_o;
    logic              ctl_clk_run_i;
    logic              ref_tick_i;
    logic              irq_o;
    logic              tick_run;
    logic              rd_d;
    logic [DATA_W-1:0] exp_q[$];
    logic [31:0]       seed;
    logic [23:0]       n_rel;
    time               t1;
    time               t2;
    int                num_errors;
    int                n_checks;
    int                cyc;

    tick_timer dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ctl_clk_run_i(ctl_clk_run_i),
        .ref_tick_i(ref_tick_i), .irq_o(irq_o));

    initial
    begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic fail(input string msg);
        num_errors++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask : fail

    // bus cycles follow the one-cycle strobe protocol, changed just after the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d; // whole 32-bit words only
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    // read notes its expectation; the monitor compares in the answer cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
    endtask : rd

    task automatic chk_irq(input logic e);
        @(negedge mclk_i);
        n_checks++;
        if (irq_o !== e)
            fail("interrupt level");
    endtask : chk_irq

    // bounded wait so a dead counter cannot hang the run
    task automatic wait_irq(output time t);
        int i;
        i = 0;
        @(negedge mclk_i);
        while (irq_o !== 1'b1 && i < 200)
        begin
            @(negedge mclk_i);
            i++;
        end
        t = $time;
        if (i == 200)
            fail("no interrupt");
    endtask : wait_irq

    // monitor: read data stand only in the cycle after the strobe
    always @(posedge mclk_i) rd_d <= rd_i;
    always @(negedge mclk_i)
    begin
        if (rd_d)
        begin
            n_checks++;
            if (exp_q.size() == 0 || rdata_o !== exp_q[0])
                fail("read data");
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end

    // reference level toggles every cycle, one count per two cycles when selected
    always @(posedge mclk_i) ref_tick_i <= tick_run ? ~ref_tick_i : 1'b0;

    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail("timeout");
            stop_test();
        end
    end

    initial
    begin
        // the reference level has its own driver above, so it is left out here
        {rst_n_i, wr_i, rd_i, ctl_clk_run_i, tick_run} = 5'h00;
        addr_i = 8'h00;
        wdata_i = 32'h00000000;
        seed = 32'h00000024;
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(OFF_CTRL_STATUS, 32'h0);
        rd(OFF_RELOAD, 32'h0);
        rd(OFF_CURRENT, 32'h0);
        rd(OFF_IRQ_STATUS, 32'h0);
        rd(OFF_IRQ_MASK, 32'h0);
        rd(8'h30, 32'h0);
        rd(OFF_CALIB, 32'hC0000000);
        seed = xs(seed);
        wr(OFF_CALIB, seed);
        rd(OFF_CALIB, 32'hC0000000);
        // write then read with no gap, so the read lands right behind the write
        seed = xs(seed);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= OFF_CALIB;
        wdata_i <= seed;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        exp_q.push_back(32'hC0000000);
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        $display("test reset and calibration done");
        seed = xs(seed);
        n_rel = {20'h00000, seed[3:0]} + 24'h000004; // reload value; the period is one clock cycle more
        wr(OFF_RELOAD, {8'h00, n_rel});
        wr(OFF_CURRENT, seed);
        wr(OFF_IRQ_MASK, 32'h1);
        wr(OFF_CTRL_STATUS, 32'h7);
        rd(OFF_RELOAD, {8'h00, n_rel});
        rd(OFF_IRQ_MASK, 32'h1);
        repeat (10) @(posedge mclk_i);
        rd(OFF_CURRENT, 32'h0);
        @(posedge mclk_i);
        ctl_clk_run_i <= 1'b1;
        wait_irq(t1);
        wr(OFF_IRQ_STATUS, 32'h1);
        chk_irq(1'b0);
        wait_irq(t2);
        n_checks++;
        if ((t2 - t1) != time'((int'(n_rel) + 1) * 4))
            fail("reload period");
        @(posedge mclk_i);
        ctl_clk_run_i <= 1'b0;
        rd(OFF_CTRL_STATUS, 32'h00010007);
        rd(OFF_CTRL_STATUS, 32'h00000007);
        wr(OFF_CURRENT, seed);
        rd(OFF_CURRENT, 32'h0);
        $display("test periodic count done");
        @(posedge mclk_i);
        ctl_clk_run_i <= 1'b1;
        repeat (int'(n_rel) + 3) @(posedge mclk_i);
        ctl_clk_run_i <= 1'b0;
        wr(OFF_CURRENT, 32'h0);
        rd(OFF_CTRL_STATUS, 32'h00000007);
        wr(OFF_IRQ_MASK, 32'h0);
        chk_irq(1'b0);
        rd(OFF_IRQ_STATUS, 32'h1);
        wr(OFF_IRQ_MASK, 32'h1);
        chk_irq(1'b1);
        wr(OFF_IRQ_STATUS, 32'h1);
        chk_irq(1'b0);
        $display("test current write and mask done");
        wr(OFF_CTRL_STATUS, 32'h1);
        @(posedge mclk_i);
        ctl_clk_run_i <= 1'b1;
        tick_run <= 1'b1;
        repeat (2 * int'(n_rel) + 8) @(posedge mclk_i);
        ctl_clk_run_i <= 1'b0;
        tick_run <= 1'b0;
        rd(OFF_CTRL_STATUS, 32'h00010001);
        rd(OFF_IRQ_STATUS, 32'h0);
        chk_irq(1'b0);
        $display("test reference source done");
        stop_test();
    end
endmodule : tick_timer_tb
`default_nettype wire
